// *** rtl/sse_pkg.sv ***
package sse_pkg;

  // ************************************************************
  // time base
  // ************************************************************
  localparam int CLK_NS    = 100;               // 10 MHz system clock
  localparam int LF_DET_NS = 75000;             // missing/too long phase
  localparam int HF_DET_NS = 8000;              // too short phase
  localparam int TICK_US   = 100;               // slow enable period

  // longest time rounds down, least time rounds up
  localparam logic [9:0] LF_CYC   = 10'(LF_DET_NS / CLK_NS);
  localparam logic [9:0] HF_CYC   = 10'((HF_DET_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [9:0] TICK_CYC = 10'(TICK_US * 1000 / CLK_NS);

  // recovery delay choices in microseconds
  localparam int REC0_US = 0;
  localparam int REC1_US = 1000;
  localparam int REC2_US = 2500;
  localparam int REC3_US = 5000;
  localparam int REC4_US = 10000;
  // inter-output delay choices in milliseconds
  localparam int SS2D0_MS = 0;
  localparam int SS2D1_MS = 10;
  localparam int SS2D2_MS = 50;
  localparam int SS2D3_MS = 100;
  localparam int SS2D4_MS = 250;

  // ************************************************************
  // register map
  // ************************************************************
  localparam logic [7:0] ADDR_CTRL = 8'h00;     // reaction configuration
  localparam logic [7:0] ADDR_WWD  = 8'h04;     // fail limit and count
  localparam logic [7:0] ADDR_STAT = 8'h08;     // safe state status
  localparam int CTRL_MODE_BIT = 0;             // 1 = recovery-delay reaction
  localparam int CTRL_REC_LSB  = 1;             // 3-bit recovery select
  localparam int CTRL_SS2_LSB  = 4;             // 3-bit inter-output select
  localparam int CTRL_REL_BIT  = 8;             // write 1 releases safe state
  localparam int WWD_CNT_LSB   = 8;             // fail count field
  localparam logic [3:0] WWD_LIMIT_RST = 4'h9;  // fail limit after reset
  localparam logic [3:0] WWD_CNT_MAX   = 4'hF;  // counter saturation

  // operating states in which the limit may change
  localparam logic [2:0] OPST_INIT   = 3'h1;
  localparam logic [2:0] OPST_NORMAL = 3'h2;
  localparam logic [2:0] OPST_WAKE   = 3'h3;

  typedef enum logic [1:0] {
    SSE_IDLE  = 2'b00,                          // outputs high
    SSE_RECOV = 2'b01,                          // recovery delay running
    SSE_DELAY = 2'b10,                          // primary low, secondary pending
    SSE_SAFE  = 2'b11                           // both low
  } sse_state_e;

  // recovery delay in slow ticks
  function automatic logic [11:0] rec_ticks(input logic [2:0] sel);
    case (sel)
      3'h0:    rec_ticks = 12'(REC0_US / TICK_US);
      3'h1:    rec_ticks = 12'(REC1_US / TICK_US);
      3'h2:    rec_ticks = 12'(REC2_US / TICK_US);
      3'h3:    rec_ticks = 12'(REC3_US / TICK_US);
      default: rec_ticks = 12'(REC4_US / TICK_US);
    endcase
  endfunction : rec_ticks

  // inter-output delay in slow ticks
  function automatic logic [11:0] ss2_ticks(input logic [2:0] sel);
    case (sel)
      3'h0:    ss2_ticks = 12'(SS2D0_MS * 1000 / TICK_US);
      3'h1:    ss2_ticks = 12'(SS2D1_MS * 1000 / TICK_US);
      3'h2:    ss2_ticks = 12'(SS2D2_MS * 1000 / TICK_US);
      3'h3:    ss2_ticks = 12'(SS2D3_MS * 1000 / TICK_US);
      default: ss2_ticks = 12'(SS2D4_MS * 1000 / TICK_US);
    endcase
  endfunction : ss2_ticks

endpackage : sse_pkg

// *** rtl/sse_mon_if.sv ***
`timescale 1ns/1ps
interface sse_mon_if;
  logic       aliveLvl;   // synchronised alive input
  logic       errLevel;   // alive error present
  logic       errPulse;   // alive error newly detected
  logic       failEvt;    // invalid watchdog trigger
  logic       validTrig;  // valid watchdog trigger
  logic [3:0] limit;      // fail limit
  logic [3:0] failCnt;    // fail count
  logic       incIrq;     // count went up
  logic       overLimit;  // count at or above limit

  modport alive (input aliveLvl, output errLevel, errPulse);
  modport wwd   (input failEvt, validTrig, limit, output failCnt, incIrq, overLimit);
  modport top   (output aliveLvl, failEvt, validTrig, limit,
                 input errLevel, errPulse, failCnt, incIrq, overLimit);
endinterface : sse_mon_if

// *** rtl/sse_alive_mon.sv ***
`timescale 1ns/1ps
module sse_alive_mon (
  input wire logic clock,
  input wire logic rstN,
  sse_mon_if.alive mon
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic       prevLvl;   // level one cycle ago
    logic       seen;      // one edge seen since reset
    logic [9:0] phaseCnt;  // cycles in current phase
    logic       errLevel;  // error held
    logic       errPulse;  // error onset
  } sse_mon_s;

  sse_mon_s r;             // registered state
  sse_mon_s n;             // next state
  logic     edgeSeen;      // alive input changed

  assign edgeSeen     = mon.aliveLvl != r.prevLvl;
  assign mon.errLevel = r.errLevel;
  assign mon.errPulse = r.errPulse;

  // each phase is timed on its own, so duty cycle does not matter
  always_comb begin
    n          = r;
    n.errPulse = 1'b0;
    n.prevLvl  = mon.aliveLvl;
    if (edgeSeen) begin
      n.phaseCnt = 10'h000;
      n.seen     = 1'b1;
      if (r.seen && r.phaseCnt < sse_pkg::HF_CYC) begin
        n.errLevel = 1'b1;
        n.errPulse = !r.errLevel;
      end else if (r.phaseCnt < sse_pkg::LF_CYC) begin
        n.errLevel = 1'b0;  // a valid phase clears the error
      end
    end else if (r.phaseCnt != sse_pkg::LF_CYC) begin
      n.phaseCnt = r.phaseCnt + 10'h001;
      if (n.phaseCnt == sse_pkg::LF_CYC) begin
        n.errLevel = 1'b1;
        n.errPulse = !r.errLevel;
      end
    end
  end

  // state register
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  property p_shortPhase;
    @(posedge clock) disable iff (!rstN)
    (edgeSeen && r.seen && r.phaseCnt < sse_pkg::HF_CYC) |=> mon.errLevel;
  endproperty
  a_shortPhase: assert property (p_shortPhase) else $error("short phase missed");

  property p_longPhase;
    @(posedge clock) disable iff (!rstN)
    (!edgeSeen && r.phaseCnt == sse_pkg::LF_CYC - 10'h001) |=> mon.errLevel;
  endproperty
  a_longPhase: assert property (p_longPhase) else $error("long phase missed");
endmodule : sse_alive_mon

// *** rtl/sse_wwd_count.sv ***
`timescale 1ns/1ps
module sse_wwd_count (
  input wire logic clock,
  input wire logic rstN,
  sse_mon_if.wwd   mon
);
  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic [3:0] cnt;     // fail count
    logic       incIrq;  // count rose last edge
  } sse_wwd_s;

  sse_wwd_s   r;         // registered state
  sse_wwd_s   n;         // next state
  logic [4:0] sum;       // widened for saturation

  assign mon.failCnt   = r.cnt;
  assign mon.incIrq    = r.incIrq;
  assign mon.overLimit = r.cnt >= mon.limit;

  // +2 on fail, -1 on valid, floor at zero, saturate at top
  always_comb begin
    sum = {1'b0, r.cnt};
    if (mon.failEvt) begin
      sum = sum + 5'h02;
    end
    if (mon.validTrig && sum != 5'h00) begin
      sum = sum - 5'h01;
    end
    n.cnt    = (sum > {1'b0, sse_pkg::WWD_CNT_MAX}) ? sse_pkg::WWD_CNT_MAX : sum[3:0];
    n.incIrq = n.cnt > r.cnt;
  end

  // state register
  always_ff @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      r <= '0;
    end else begin
      r <= n;
    end
  end

  property p_addTwo;
    @(posedge clock) disable iff (!rstN)
    (mon.failEvt && !mon.validTrig && r.cnt < 4'hE) |=> r.cnt == $past(r.cnt) + 4'h2;
  endproperty
  a_addTwo: assert property (p_addTwo) else $error("fail did not add two");

  property p_irqRise;
    @(posedge clock) disable iff (!rstN)
    (r.cnt != $past(r.cnt)) |-> (r.incIrq == (r.cnt > $past(r.cnt)));
  endproperty
  a_irqRise: assert property (p_irqRise) else $error("irq not tied to rise");

  property p_floor;
    @(posedge clock) disable iff (!rstN)
    (mon.validTrig && !mon.failEvt && r.cnt == 4'h0) |=> r.cnt == 4'h0 && !r.incIrq;
  endproperty
  a_floor: assert property (p_floor) else $error("count went below zero");
endmodule : sse_wwd_count

// *** rtl/sse_top.sv ***
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
// How it works
// - no edge past long limit flags error
// - edge-to-edge under short limit flags error
// - high and low phases timed separately
// - any too-short single phase is error
// - immediate mode drops primary output at once
// - secondary follows primary after programmed delay
// - recovery mode raises interrupt, starts delay
// - error still present at expiry enters safe
// - valid toggling before expiry keeps outputs high
// - soft reset fall: primary now, secondary delayed
// - hard reset fall: both outputs low together
// - fail counter plus two, minus one
// - interrupt only when fail counter rises
// - fail counter never below zero
// - limit writable only in init, normal, wake
// - count at or above limit enters safe
// - long detection time within 50.1-99.9 us
// - short detection time within 5.2-11.1 us
// - recovery delay 0, 1, 2.5, 5, 10 ms
module sse_top #(
  parameter logic [9:0] TICK_CYCLES = sse_pkg::TICK_CYC  // slow tick period in clocks
) (
  input  wire logic        clock,
  input  wire logic        rst_n,
  input  wire logic        aliveIn,              // toggling alive pin, asynchronous
  input  wire logic        resetOutputLine,      // reset output line, same clock
  input  wire logic        resetIsError,         // line fall was error triggered
  input  wire logic        resetIsHard,          // line fall is a hard reset
  input  wire logic        wwdFailEvent,         // invalid window watchdog trigger
  input  wire logic        wwdValidTrig,         // valid window watchdog trigger
  input  wire logic [2:0]  opState,              // device operating state
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             safeStateOutPrimaryN,
  output logic             safeStateOutSecondaryN,
  output logic             irqAliveErr,          // recovery delay started
  output logic             irqWwdInc             // fail count rose
);
  // ************************************************************
  // reset release
  // ************************************************************
  logic [1:0] rstPipe;   // release synchroniser
  logic       rstSyncN;  // reset used by all other logic

  // assert at once, release after two edges
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstPipe <= 2'h0;
    end else begin
      rstPipe <= {rstPipe[0], 1'b1};
    end
  end
  assign rstSyncN = rstPipe[1];

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    logic                aliveMeta;  // first sync stage
    logic                aliveSync;  // second sync stage
    logic                rotPrev;    // reset line one cycle ago
    logic [9:0]          divCnt;     // slow tick divider
    logic                tick;       // slow enable pulse
    sse_pkg::sse_state_e st;         // reaction state
    logic [11:0]         tmr;        // recovery or inter-output timer
    logic                reactRec;   // recovery-delay reaction selected
    logic [2:0]          recSel;     // recovery delay choice
    logic [2:0]          ss2Sel;     // inter-output delay choice
    logic [3:0]          limit;      // fail limit
    logic                pready;     // bus answer
    logic [31:0]         prdata;     // read data
    logic                pslverr;    // unmapped address
    logic                ss1N;       // primary safe output
    logic                ss2N;       // secondary safe output
    logic                irqAlive;   // recovery start pulse
  } sse_top_s;

  sse_top_s  r;           // registered state
  sse_top_s  n;           // next state
  sse_mon_if mon ();      // monitor and counter link

  logic        access;    // access phase waiting for answer
  logic        commit;    // write takes effect this edge
  logic        releaseHit;// software releases safe state
  logic        limitWr;   // limit write allowed and present
  logic        stateOk;   // operating state permits limit change
  logic        rotFall;   // error triggered reset line fall
  logic        hardTrig;  // hard reset fall
  logic        softTrig;  // soft reset fall
  logic        safeTrig;  // immediate safe state cause other than hard reset
  logic [11:0] ss2Dly;    // chosen inter-output delay

  // ************************************************************
  // submodules
  // ************************************************************
  assign mon.aliveLvl  = r.aliveSync;
  assign mon.failEvt   = wwdFailEvent;
  assign mon.validTrig = wwdValidTrig;
  assign mon.limit     = r.limit;

  sse_alive_mon uAlive (
    .clock (clock),
    .rstN  (rstSyncN),
    .mon   (mon.alive)
  );

  sse_wwd_count uWwd (
    .clock (clock),
    .rstN  (rstSyncN),
    .mon   (mon.wwd)
  );

  // ************************************************************
  // decode
  // ************************************************************
  assign access     = psel && penable && !r.pready;
  assign commit     = psel && penable && r.pready && pwrite && !r.pslverr;
  assign releaseHit = commit && paddr == sse_pkg::ADDR_CTRL && pwdata[sse_pkg::CTRL_REL_BIT];
  assign stateOk    = opState == sse_pkg::OPST_INIT || opState == sse_pkg::OPST_NORMAL
                      || opState == sse_pkg::OPST_WAKE;
  assign limitWr    = commit && paddr == sse_pkg::ADDR_WWD && stateOk;
  assign rotFall    = r.rotPrev && !resetOutputLine && resetIsError;
  assign hardTrig   = rotFall && resetIsHard;
  assign softTrig   = rotFall && !resetIsHard;
  // immediate causes; in recovery mode alive errors wait instead
  assign safeTrig   = softTrig || mon.overLimit || (mon.errPulse && !r.reactRec);
  assign ss2Dly     = sse_pkg::ss2_ticks(r.ss2Sel);

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    n           = r;
    n.aliveMeta = aliveIn;
    n.aliveSync = r.aliveMeta;
    n.rotPrev   = resetOutputLine;
    n.irqAlive  = 1'b0;
    // slow tick; timer resolution is one tick, well inside time base tolerance
    n.tick      = r.divCnt == TICK_CYCLES - 10'h001;
    n.divCnt    = n.tick ? 10'h000 : r.divCnt + 10'h001;

    // apb: one wait state, answer registered
    n.pready = access;
    if (access) begin
      n.pslverr = 1'b0;
      unique case (paddr)
        sse_pkg::ADDR_CTRL: begin
          n.prdata = {25'h0, r.ss2Sel, r.recSel, r.reactRec};
        end
        sse_pkg::ADDR_WWD: begin
          n.prdata = {20'h0, mon.failCnt, 4'h0, r.limit};
        end
        sse_pkg::ADDR_STAT: begin
          n.prdata = {26'h0, mon.overLimit, mon.errLevel, r.st, r.ss2N, r.ss1N};
        end
        default: begin
          n.prdata  = 32'h0000_0000;  // unmapped reads zero with error
          n.pslverr = 1'b1;
        end
      endcase
    end
    if (commit && paddr == sse_pkg::ADDR_CTRL) begin
      n.reactRec = pwdata[sse_pkg::CTRL_MODE_BIT];
      n.recSel   = pwdata[sse_pkg::CTRL_REC_LSB +: 3];
      n.ss2Sel   = pwdata[sse_pkg::CTRL_SS2_LSB +: 3];
    end
    if (limitWr) begin
      n.limit = pwdata[3:0];
    end

    // reaction sequencer
    unique case (r.st)
      sse_pkg::SSE_IDLE: begin
        if (safeTrig) begin
          n.st  = (ss2Dly == 12'h000) ? sse_pkg::SSE_SAFE : sse_pkg::SSE_DELAY;
          n.tmr = ss2Dly;
        end else if (mon.errPulse) begin
          n.st       = sse_pkg::SSE_RECOV;
          n.tmr      = sse_pkg::rec_ticks(r.recSel);
          n.irqAlive = 1'b1;
        end
      end
      sse_pkg::SSE_RECOV: begin
        if (safeTrig || (r.tmr == 12'h000 && mon.errLevel)) begin
          n.st  = (ss2Dly == 12'h000) ? sse_pkg::SSE_SAFE : sse_pkg::SSE_DELAY;
          n.tmr = ss2Dly;
        end else if (r.tmr == 12'h000) begin
          n.st = sse_pkg::SSE_IDLE;
        end else if (r.tick) begin
          n.tmr = r.tmr - 12'h001;
        end
      end
      sse_pkg::SSE_DELAY: begin
        if (r.tmr == 12'h000) begin
          n.st = sse_pkg::SSE_SAFE;
        end else if (r.tick) begin
          n.tmr = r.tmr - 12'h001;
        end
      end
      sse_pkg::SSE_SAFE: begin
        // a count still at or above limit, or a new trigger this cycle, keeps the outputs low
        if (releaseHit && !safeTrig) begin
          n.st = sse_pkg::SSE_IDLE;
        end
      end
    endcase
    // hard reset: regulator is off, both drop together
    if (hardTrig) begin
      n.st = sse_pkg::SSE_SAFE;
    end
    n.ss1N = !(n.st == sse_pkg::SSE_DELAY || n.st == sse_pkg::SSE_SAFE);
    n.ss2N = n.st != sse_pkg::SSE_SAFE;
  end

  // ************************************************************
  // state register
  // ************************************************************
  always_ff @(posedge clock or negedge rstSyncN) begin
    if (!rstSyncN) begin
      r          <= '0;
      r.st       <= sse_pkg::SSE_IDLE;
      r.limit    <= sse_pkg::WWD_LIMIT_RST;
      r.rotPrev  <= 1'b1;
      r.ss1N     <= 1'b1;
      r.ss2N     <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign prdata                 = r.prdata;
  assign pready                 = r.pready;
  assign pslverr                = r.pslverr;
  assign safeStateOutPrimaryN   = r.ss1N;
  assign safeStateOutSecondaryN = r.ss2N;
  assign irqAliveErr            = r.irqAlive;
  assign irqWwdInc              = mon.incIrq;

  // ************************************************************
  // checks
  // ************************************************************
  property p_immediate;
    @(posedge clock) disable iff (!rstSyncN)
    (r.st inside {sse_pkg::SSE_IDLE, sse_pkg::SSE_RECOV} && mon.errPulse && !r.reactRec)
      |=> !safeStateOutPrimaryN;
  endproperty
  a_immediate: assert property (p_immediate) else $error("immediate drop missed");

  property p_ss2Follow;
    @(posedge clock) disable iff (!rstSyncN)
    (r.st == sse_pkg::SSE_DELAY && r.tmr == 12'h000) |=> !safeStateOutSecondaryN;
  endproperty
  a_ss2Follow: assert property (p_ss2Follow) else $error("secondary not dropped");

  property p_recStart;
    @(posedge clock) disable iff (!rstSyncN)
    (r.st == sse_pkg::SSE_IDLE && mon.errPulse && r.reactRec && !safeTrig && !hardTrig)
      |=> irqAliveErr && safeStateOutPrimaryN;
  endproperty
  a_recStart: assert property (p_recStart) else $error("recovery start missed");

  sequence s_recExpireErr;
    r.st == sse_pkg::SSE_RECOV && r.tmr == 12'h000 && mon.errLevel && !hardTrig;
  endsequence
  sequence s_primaryLow;
    !safeStateOutPrimaryN ##1 !safeStateOutPrimaryN;
  endsequence
  property p_recExpire;
    @(posedge clock) disable iff (!rstSyncN)
    s_recExpireErr |=> s_primaryLow;
  endproperty
  a_recExpire: assert property (p_recExpire) else $error("expiry did not drop");

  property p_recOk;
    @(posedge clock) disable iff (!rstSyncN)
    (r.st == sse_pkg::SSE_RECOV && r.tmr == 12'h000 && !mon.errLevel && !safeTrig
      && !hardTrig) |=> safeStateOutPrimaryN && safeStateOutSecondaryN;
  endproperty
  a_recOk: assert property (p_recOk) else $error("recovered but dropped");

  property p_soft;
    @(posedge clock) disable iff (!rstSyncN)
    (r.st == sse_pkg::SSE_IDLE && softTrig) |=> !safeStateOutPrimaryN;
  endproperty
  a_soft: assert property (p_soft) else $error("soft reset drop missed");

  property p_hard;
    @(posedge clock) disable iff (!rstSyncN)
    hardTrig |=> !safeStateOutPrimaryN && !safeStateOutSecondaryN;
  endproperty
  a_hard: assert property (p_hard) else $error("hard reset drop missed");

  property p_limitLock;
    @(posedge clock) disable iff (!rstSyncN)
    !limitWr |=> $stable(r.limit);
  endproperty
  a_limitLock: assert property (p_limitLock) else $error("limit changed while locked");

  property p_overLimit;
    @(posedge clock) disable iff (!rstSyncN)
    mon.overLimit |=> !safeStateOutPrimaryN;
  endproperty
  a_overLimit: assert property (p_overLimit) else $error("limit drop missed");

  property p_hold;
    @(posedge clock) disable iff (!rstSyncN)
    (!safeStateOutPrimaryN && !releaseHit) |=> !safeStateOutPrimaryN;
  endproperty
  a_hold: assert property (p_hold) else $error("safe state left unreleased");
endmodule : sse_top

// *** verification/sse_mcu_model.sv ***
`timescale 1ns/1ps
// ***********************
// controller alive toggler
// ***********************
module sse_mcu_model (
  input  wire logic       clock,
  input  wire logic [9:0] halfCyc,  // phase length in clocks, 0 stops
  output logic            aliveIn   // alive toggle towards the block
);
  logic [9:0] cnt;                  // clocks in current phase
  initial begin
    aliveIn = 1'b0;
    cnt = 10'h000;
  end
  // stuck level when stopped, so a dead controller looks dead
  always @(posedge clock) begin
    if (halfCyc == 10'h000) begin
      cnt <= 10'h000;
    end else if (cnt + 10'h001 >= halfCyc) begin
      cnt <= 10'h000;
      aliveIn <= ~aliveIn;
    end else begin
      cnt <= cnt + 10'h001;
    end
  end
endmodule : sse_mcu_model

// *** verification/sse_top_tb_top.sv ***
`timescale 1ns/1ps
module sse_top_tb_top;
  // ***********************
  // stimulus and checks
  // ***********************
  logic clock = 1'b0, rst_n = 1'b0, rstLine, isErr, isHard, fail, valid;
  logic psel, penable, pwrite, pready, pslverr, prim, sec, irqAlive, irqInc, aliveIn;
  logic [2:0]  opState;    // operating state code
  logic [7:0]  paddr;
  logic [9:0]  halfCyc;    // controller phase length
  logic [31:0] pwdata, prdata, rd;
  int n_errors = 0;
  int total_checks = 0;
  always #50 clock = ~clock;
  sse_mcu_model sse_mcu_model_inst (.clock(clock), .halfCyc(halfCyc), .aliveIn(aliveIn));
  // short tick of ten clocks keeps each millisecond of delay to a hundred clocks
  sse_top #(.TICK_CYCLES(10'h00A)) sse_top_inst (.clock(clock), .rst_n(rst_n),
    .aliveIn(aliveIn), .resetOutputLine(rstLine), .resetIsError(isErr),
    .resetIsHard(isHard), .wwdFailEvent(fail), .wwdValidTrig(valid), .opState(opState),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .safeStateOutPrimaryN(prim),
    .safeStateOutSecondaryN(sec), .irqAliveErr(irqAlive), .irqWwdInc(irqInc));
  task automatic close_out;
    if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : close_out
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // one apb transfer, held until pready is seen
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1 && ++i < 20);
    if (i >= 20) begin
      chk(1'b0, 1'b1);
      close_out();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // let the release reach the bus before the next setup drives psel again
    @(posedge clock);
  endtask : apb
  function automatic logic pick(input int s);
    return s == 0 ? prim : s == 1 ? sec : s == 2 ? irqAlive : irqInc;
  endfunction : pick
  // bounded wait for a level, then compare
  task automatic waitFor(input int s, input logic v, input int m);
    int i = 0;
    while (pick(s) !== v && i < m) begin
      @(posedge clock);
      i++;
    end
    chk(pick(s), v);
    if (i >= m) close_out();
  endtask : waitFor
  task automatic hold(input int s, input logic v, input int n);
    logic ok = 1'b1;
    repeat (n) begin
      @(posedge clock);
      ok &= (pick(s) === v);
    end
    chk(ok, 1'b1);
  endtask : hold
  task automatic trig(input logic f, input logic v);
    fail <= f;
    valid <= v;
    @(posedge clock);
    fail <= 1'b0;
    valid <= 1'b0;
    @(posedge clock);
  endtask : trig
  initial begin
    {psel, penable, pwrite, fail, valid, isErr, isHard} = 7'h00;
    paddr = 8'h00;
    pwdata = 32'h0;
    opState = 3'h2;
    rstLine = 1'b1;
    halfCyc = 10'h0C8;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    repeat (400) @(posedge clock);
    apb(1'b0, 8'h3C, 32'h0);
    chk({rd[0], pslverr}, 2'h1);
    apb(1'b1, sse_pkg::ADDR_CTRL, 32'h5);
    halfCyc <= 10'h000;
    waitFor(2, 1'b1, 800);
    halfCyc <= 10'h05A;
    hold(0, 1'b1, 400);
    halfCyc <= 10'h000;
    waitFor(2, 1'b1, 800);
    waitFor(0, 1'b0, 300);
    chk(sec, 1'b0);
    halfCyc <= 10'h0C8;
    repeat (500) @(posedge clock);
    apb(1'b1, sse_pkg::ADDR_CTRL, 32'h110);
    chk({prim, sec}, 2'h3);
    halfCyc <= 10'h028;
    waitFor(0, 1'b0, 150);
    halfCyc <= 10'h0C8;
    hold(1, 1'b1, 980);
    waitFor(1, 1'b0, 40);
    chk(prim, 1'b0);
    apb(1'b1, sse_pkg::ADDR_CTRL, 32'h110);
    isErr <= 1'b1;
    rstLine <= 1'b0;
    waitFor(0, 1'b0, 3);
    hold(1, 1'b1, 900);
    rstLine <= 1'b1;
    waitFor(1, 1'b0, 200);
    apb(1'b1, sse_pkg::ADDR_CTRL, 32'h110);
    isHard <= 1'b1;
    rstLine <= 1'b0;
    waitFor(0, 1'b0, 3);
    chk(sec, 1'b0);
    rstLine <= 1'b1;
    opState <= 3'h5;
    apb(1'b1, sse_pkg::ADDR_WWD, 32'h3);
    apb(1'b0, sse_pkg::ADDR_WWD, 32'h0);
    chk(rd, 32'h9);
    opState <= 3'h2;
    apb(1'b1, sse_pkg::ADDR_WWD, 32'h3);
    trig(1'b1, 1'b0);
    waitFor(3, 1'b1, 4);
    apb(1'b0, sse_pkg::ADDR_WWD, 32'h0);
    chk(rd, 32'h203);
    trig(1'b0, 1'b1);
    hold(3, 1'b0, 6);
    trig(1'b0, 1'b1);
    trig(1'b0, 1'b1);
    apb(1'b0, sse_pkg::ADDR_WWD, 32'h0);
    chk(rd, 32'h003);
    // leave the hard reset safe state so the limit crossing is what drops the output
    apb(1'b1, sse_pkg::ADDR_CTRL, 32'h110);
    chk(prim, 1'b1);
    trig(1'b1, 1'b0);
    trig(1'b1, 1'b0);
    waitFor(0, 1'b0, 4);
    close_out();
  end
endmodule : sse_top_tb_top
